//--- core/pbsp_regs.svh
// register offsets, field positions and reset values of the port logic
`ifndef PBSP_REGS_SVH
`define PBSP_REGS_SVH

// ************************************************************
// register map (byte offsets, low address bits)
// ************************************************************
`define PBSP_ADDR_W   8
`define PBSP_DATA_OFS 8'h00
`define PBSP_DIR_OFS  8'h04
`define PBSP_PDI_OFS  8'h08
`define PBSP_OPT_OFS  8'h0C

// ************************************************************
// widths, fields and reset values
// ************************************************************
`define PBSP_NPINS    7
`define PBSP_OPT_W    2
`define PBSP_OPT_GPD  0
`define PBSP_OPT_CPS  1
`define PBSP_PIN4     4
`define PBSP_PIN5     5
`define PBSP_PIN6     6
`define PBSP_DIR_RST  7'h00
`define PBSP_PDI_RST  7'h00
`define PBSP_OPT_RST  2'h0

`endif

//--- core/pbsp_pkg.sv
// types shared by the port b shared pin logic
package pbsp_pkg;

  // signals arriving from the timer, comparator and serial port
  typedef struct packed {
    logic serialPortEnable;
    logic serialDataOut;
    logic compareOutputLevel;
    logic comparator1Result;
    logic comparator1OutputEnable;
  } pbsp_share_t;

  // option register layout, bit 1 down to bit 0
  typedef struct packed {
    logic comparatorPinSelect;
    logic globalPulldownDisable;
  } pbsp_opt_t;

endpackage : pbsp_pkg

//--- core/pbsp_pin_logic.sv
// port b pins 0..6: shared pin muxing, pulldowns and ahb-lite registers
//
// Behaviour
// [R1] pins 0-3 as output drive the latch, pulldown off
// [R2] pins 0-3 as input read back the digital pin level
// [R3] active input pulldown stays on, loading other pin users
// [R4] global pulldown disable forces every pulldown off
// [R5] pin 4 drives latch OR compare level OR gated comparator
// [R6] pin 4 always feeds analog channel four
// [R7] software sets direction, clears data and select for compare out
// [R8] software sets direction, clears compare and select for data out
// [R9] comparator reaches pin 4 only with select and output enable
// [R10] pin 4 input: driver off, read gives pin level
// [R11] serial enable: pin 5 driven from serial data out, no pulldown
// [R12] serial enable: pin 6 undriven, feeds serial data in
// [R13] serial owned pins keep direction and data readable and writable
// [R14] serial disable returns pins 5, 6 to stored settings at once
// [R15] software clears serial enable and direction for plain input
// [R16] software clears serial enable, sets direction for pin 6 output
// [R17] direction register always readable and writable
// [R18] inhibit one turns pulldown off; zero enables it on inputs
// [R19] reset clears direction and inhibit, keeps data latches
// [R20] pulldown is not-disable, not-inhibit, not-output, not-takeover
// [R21] pin 4 output with compare or comparator high reads one
`timescale 1ns/100ps
`include "pbsp_regs.svh"

module pbsp_pin_logic
(
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // on-chip sharing modules
  input  wire pbsp_pkg::pbsp_share_t shareIn,
  // pins
  input  wire logic [6:0]         pinIn,
  output logic      [6:0]         pinOut,
  output logic      [6:0]         pinOe,
  output logic      [6:0]         pulldownEn,
  // levels handed to sharing modules
  output logic                    analogChannelFour,
  output logic      [3:0]         sharedInput,
  output logic                    serialDataIn
);

  localparam int NP = `PBSP_NPINS;

  // ************************************************************
  // functions
  // ************************************************************

  // per-bit select: sel high takes a, else b
  function automatic logic [NP-1:0] pickBits
  (
    input logic [NP-1:0] sel,
    input logic [NP-1:0] a,
    input logic [NP-1:0] b
  );
    pickBits = (sel & a) | (~sel & b);
  endfunction : pickBits

  // widen a register view onto the 32-bit read bus
  function automatic logic [31:0] zext(input logic [NP-1:0] v);
    zext = {25'h0000000, v};
  endfunction : zext

  // ************************************************************
  // pin input synchroniser
  // ************************************************************
  logic [NP-1:0] pinMeta;
  logic [NP-1:0] pinSync;

  // pins are asynchronous; two stages before any reader
  always_ff @(posedge ref_clk)
  begin
    pinMeta <= pinIn;
    pinSync <= pinMeta;
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [NP-1:0]       portLatch;
  logic [NP-1:0]       portDirection;
  logic [NP-1:0]       pulldownInhibit;
  pbsp_pkg::pbsp_opt_t optionReg;

  // ahb address phase capture
  logic                   apWrite;
  logic [`PBSP_ADDR_W-1:0] apAddr;
  wire  logic             addrTaken;

  // a transfer is taken when selected, non-idle and bus ready
  assign addrTaken = hsel & htrans[1] & hready;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      apWrite <= 1'b0;
      apAddr  <= `PBSP_DATA_OFS;
    end
    else if (hready)
    begin
      apWrite <= addrTaken & hwrite;
      apAddr  <= haddr[`PBSP_ADDR_W-1:0];
    end
  end

  // data-phase write strobes, hsize not checked
  wire logic wrData;
  wire logic wrDir;
  wire logic wrPdi;
  wire logic wrOpt;
  assign wrData = apWrite & (apAddr == `PBSP_DATA_OFS);
  assign wrDir  = apWrite & (apAddr == `PBSP_DIR_OFS);
  assign wrPdi  = apWrite & (apAddr == `PBSP_PDI_OFS);
  assign wrOpt  = apWrite & (apAddr == `PBSP_OPT_OFS);

  // data latches have no reset: their contents survive it
  always_ff @(posedge ref_clk)
  begin
    if (wrData)
      portLatch <= hwdata[NP-1:0]; // R13
  end

  // direction, inhibit and options clear on reset
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      portDirection   <= `PBSP_DIR_RST; // R19
      pulldownInhibit <= `PBSP_PDI_RST; // R19
      optionReg       <= `PBSP_OPT_RST;
    end
    else
    begin
      if (wrDir)
        portDirection <= hwdata[NP-1:0]; // R17
      if (wrPdi)
        pulldownInhibit <= hwdata[NP-1:0];
      if (wrOpt)
        optionReg <= hwdata[`PBSP_OPT_W-1:0];
    end
  end

  // ************************************************************
  // pin multiplexing
  // ************************************************************
  wire logic          serial_port_enable;
  wire logic          cmpGated;
  wire logic [NP-1:0] takeover;
  wire logic [NP-1:0] effOe;
  wire logic [NP-1:0] pinValue;
  wire logic [NP-1:0] latchView;

  assign serial_port_enable = shareIn.serialPortEnable;
  // comparator only counts with both select and enable
  assign cmpGated = optionReg.comparatorPinSelect  // R9
                  & shareIn.comparator1OutputEnable
                  & shareIn.comparator1Result;

  // serial port owns pins 5 and 6 only while enabled, so clearing
  // the enable hands them straight back to the stored bits
  assign takeover = {serial_port_enable, serial_port_enable, 5'h00}; // R14

  // output enable: pin 5 forced on, pin 6 forced off by serial
  assign effOe = {portDirection[6] & ~serial_port_enable,  // R12
                  portDirection[5] | serial_port_enable,   // R11
                  portDirection[4:0]};      // R1

  // value offered to each driver
  assign pinValue = {portLatch[6],
                     serial_port_enable ? shareIn.serialDataOut : portLatch[5], // R11
                     portLatch[4] | shareIn.compareOutputLevel
                       | cmpGated,                               // R5
                     portLatch[3:0]};                            // R1

  // idle drivers show zero so no undriven latch leaks out
  assign pinOut = effOe & pinValue;
  assign pinOe  = effOe; // R10

  // pulldown: off if disabled, inhibited, driving or taken over
  assign pulldownEn = ~{NP{optionReg.globalPulldownDisable}} // R4
                    & ~pulldownInhibit                         // R18
                    & ~effOe                                   // R3
                    & ~takeover;                               // R20

  // analog path and shared inputs see the pin whatever drives it
  assign analogChannelFour = pinSync[`PBSP_PIN4]; // R6
  assign sharedInput       = pinSync[3:0];
  assign serialDataIn      = serial_port_enable & pinSync[`PBSP_PIN6]; // R12

  // ************************************************************
  // read path
  // ************************************************************
  wire logic [NP-1:0] portRead;
  wire logic [NP-1:0] dirView;
  wire logic [31:0]   next_hrdata;
  wire logic          rdTaken;

  // pin 4 reads its ORed level when driving
  assign latchView = {portLatch[6:5], pinValue[4], portLatch[3:0]}; // R21

  // output pins read latchView (latch, pin 4 its ORed level), inputs read the pin level
  assign portRead = pickBits(portDirection, latchView, pinSync); // R2

  // a direction write in its data phase is forwarded to a read behind it
  assign dirView = wrDir ? hwdata[NP-1:0] : portDirection; // R17

  assign rdTaken = addrTaken & ~hwrite;

  // read mux; inhibit register is write-only and reads zero
  assign next_hrdata =
    !rdTaken ? 32'h00000000 :
    (haddr[`PBSP_ADDR_W-1:0] == `PBSP_DATA_OFS) ? zext(portRead) :
    (haddr[`PBSP_ADDR_W-1:0] == `PBSP_DIR_OFS)  ? zext(dirView) :
    (haddr[`PBSP_ADDR_W-1:0] == `PBSP_OPT_OFS)
      ? {30'h00000000, wrOpt ? hwdata[`PBSP_OPT_W-1:0] : optionReg}
      : 32'h00000000;

  // read data is ready at the start of the data phase
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      hrdata <= 32'h00000000;
    else if (hready)
      hrdata <= next_hrdata;
  end

  // zero wait states and never an error
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // helpers: a data-register or direction-register read that was taken last cycle
  logic rdDataPrev;
  logic rdDirPrev;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rdDataPrev <= 1'b0;
      rdDirPrev  <= 1'b0;
    end
    else
    begin
      rdDataPrev <= rdTaken
                  & (haddr[`PBSP_ADDR_W-1:0] == `PBSP_DATA_OFS);
      rdDirPrev  <= rdTaken
                  & (haddr[`PBSP_ADDR_W-1:0] == `PBSP_DIR_OFS);
    end
  end

  AST_LOW_OUT: assert property ( // R1
    portDirection[0] |-> pinOe[0] && !pulldownEn[0]
      && pinOut[0] == portLatch[0])
    else $error("pin 0 output not driven from latch");

  AST_LOW_READ: assert property ( // R2
    rdDataPrev && $past(portDirection[3:0]) == 4'h0
      |-> hrdata[3:0] == $past(pinSync[3:0]))
    else $error("input pin read is not the pin level");

  AST_PD_ON: assert property ( // R3
    !optionReg.globalPulldownDisable && !pulldownInhibit[2]
      && !portDirection[2] |-> pulldownEn[2])
    else $error("input pulldown not connected");

  AST_GPD_OFF: assert property ( // R4
    optionReg.globalPulldownDisable |-> pulldownEn == 7'h00)
    else $error("pulldown on under global disable");

  AST_PIN4_OR: assert property ( // R5
    portDirection[4] && shareIn.compareOutputLevel
      |-> pinOe[4] && pinOut[4])
    else $error("compare level missing on pin 4");

  AST_ANALOG: assert property ( // R6
    analogChannelFour == $past(pinMeta[4]))
    else $error("analog channel lost pin 4");

  AST_CMP_GATE: assert property ( // R9
    !(optionReg.comparatorPinSelect
      && shareIn.comparator1OutputEnable)
      && !portLatch[4] && !shareIn.compareOutputLevel
      |-> !pinOut[4])
    else $error("ungated comparator reached pin 4");

  AST_PIN4_IN: assert property ( // R10
    !portDirection[4] |-> !pinOe[4] && !pinOut[4])
    else $error("pin 4 driven while input");

  AST_SER_OUT: assert property ( // R11
    serial_port_enable |-> pinOe[5] && !pulldownEn[5]
      && pinOut[5] == shareIn.serialDataOut)
    else $error("pin 5 not serial output");

  AST_SER_IN: assert property ( // R12
    serial_port_enable |-> !pinOe[6] && !pulldownEn[6]
      && serialDataIn == pinSync[6])
    else $error("pin 6 not serial input");

  AST_SER_READ: assert property ( // R13
    rdDataPrev && $past(serial_port_enable) && !$past(portDirection[6])
      |-> hrdata[6] == $past(pinSync[6]))
    else $error("serial pin read is not the pin level");

  AST_SER_FREE: assert property ( // R14
    $fell(serial_port_enable) |-> pinOe[6:5] == portDirection[6:5])
    else $error("pins 5,6 not released at once");

  AST_DIR_RW: assert property ( // R17
    rdDirPrev |-> hrdata[6:0] == portDirection)
    else $error("direction readback mismatch");

  AST_PDI_OFF: assert property ( // R18
    pulldownInhibit[1] |-> !pulldownEn[1])
    else $error("inhibited pulldown still on");

  AST_RST_CLR: assert property ( // R19
    $past(reset) |-> portDirection == 7'h00
      && pulldownInhibit == 7'h00 && pinOe[4:0] == 5'h00)
    else $error("reset left direction or inhibit set");

  AST_PIN4_READ: assert property ( // R21
    rdDataPrev && $past(portDirection[4])
      && $past(shareIn.compareOutputLevel) |-> hrdata[4])
    else $error("pin 4 read not ORed level");

  COV_SERIAL: cover property (
    $rose(serial_port_enable) ##[1:20] $fell(serial_port_enable));
  COV_COMPARE: cover property (
    portDirection[4] && cmpGated && pinOut[4]);
  COV_READ_PIN: cover property (
    rdDataPrev && portDirection == 7'h00);

endmodule : pbsp_pin_logic

//--- tb/pbsp_pin_model.sv
// pin model: resolves each shared pin from every party that drives it
`timescale 1ns/100ps

module pbsp_pin_model
(
  // clock
  input  wire logic       ref_clk,
  // device side of the pins
  input  wire logic [6:0] pinOut,
  input  wire logic [6:0] pinOe,
  input  wire logic [6:0] pulldownEn,
  // outside drivers
  input  wire logic [6:0] extEn,
  input  wire logic [6:0] extVal,
  // resolved levels
  output logic      [6:0] pinIn
);
  logic [6:0] floatVal;

  // a floating pin has no stable level, so it flips every cycle
  initial floatVal = 7'h00;
  always @(posedge ref_clk) floatVal <= ~floatVal;

  // device drive wins over the outside, then outside, then pulldown
  assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal)
               | (~pinOe & ~extEn & ~pulldownEn & floatVal);
endmodule : pbsp_pin_model

//--- tb/testbench.sv
// self-checking bench for the port b shared pin logic
`timescale 1ns/100ps
`include "pbsp_regs.svh"

module testbench;
  // corner setups: direction, inhibit, option, data, share signals
  localparam logic [27:0] CORNER [8] = '{
    {7'h10, 7'h00, 2'h0, 7'h00, 5'h04},
    {7'h10, 7'h00, 2'h0, 7'h10, 5'h00},
    {7'h10, 7'h00, 2'h2, 7'h00, 5'h03},
    {7'h10, 7'h00, 2'h2, 7'h00, 5'h02},
    {7'h00, 7'h00, 2'h0, 7'h00, 5'h18},
    {7'h60, 7'h00, 2'h0, 7'h20, 5'h10},
    {7'h00, 7'h60, 2'h0, 7'h00, 5'h00},
    {7'h40, 7'h00, 2'h1, 7'h40, 5'h00}};

  logic ref_clk, reset, hsel, hwrite, hreadyout, hresp;
  logic serialDataIn, analogChannelFour;
  logic [1:0] htrans, comparator_pin_select;
  logic [2:0] hsize;
  logic [3:0] sharedInput;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [6:0] pinIn, pinOut, pinOe, pulldownEn, extEn, extVal;
  logic [6:0] dir, pdi, dat, m;
  logic [41:0] e;
  logic [5:0] lm;
  pbsp_pkg::pbsp_share_t shareIn, sh;
  int errors, total_checks;

  pbsp_pin_logic dut_u (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .shareIn(shareIn),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pulldownEn(pulldownEn), .analogChannelFour(analogChannelFour),
    .sharedInput(sharedInput), .serialDataIn(serialDataIn));

  pbsp_pin_model pins_u (.ref_clk(ref_clk), .pinOut(pinOut),
    .pinOe(pinOe), .pulldownEn(pulldownEn), .extEn(extEn),
    .extVal(extVal), .pinIn(pinIn));

  // ************************************************************
  // clock and watchdog
  // ************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // the tests need about 1000 cycles; twenty times that means a hang
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ready is looked at as it stands at the rising edge itself
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 50) errors++;
  endtask : wait_ready

  // one single ahb-lite transfer, address phase then data phase
  task automatic bus_xfer(input logic wr, input logic [7:0] adr,
                          input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, adr};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    // read data and response are taken at the edge ending the data phase
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : bus_xfer

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // oe, out, pulldown, level, known mask, read value
  function automatic logic [41:0] expect_pins();
    logic serial_port_enable;
    logic [6:0] oe, val, out, pd, lvl, kn;
    serial_port_enable = sh.serialPortEnable;
    oe = dir;
    oe[5] = dir[5] | serial_port_enable;
    oe[6] = dir[6] & ~serial_port_enable;
    val = dat;
    val[4] = dat[4] | sh.compareOutputLevel | (comparator_pin_select[1]
           & sh.comparator1OutputEnable & sh.comparator1Result);
    out = val;
    out[5] = serial_port_enable ? sh.serialDataOut : dat[5];
    out = out & oe;
    pd = ~{7{comparator_pin_select[0]}} & ~pdi & ~oe & ~{serial_port_enable, serial_port_enable, 5'h00};
    kn = oe | extEn | pd;
    lvl = out | (~oe & extEn & extVal);
    return {oe, out, pd, lvl, kn, (dir & val) | (~dir & lvl)};
  endfunction : expect_pins

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
    hsize = 3'h2;
    shareIn = '0;
    extEn = 7'h00;
    extVal = 7'h00;
    errors = 0;
    total_checks = 0;
    reset = 1'b1;
    void'($urandom(32'h776e6963));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check({25'h0, pinOe}, 32'h0);
    check({25'h0, pulldownEn}, 32'h7F);
    // data latch survives a second reset, direction does not
    bus_xfer(1'b1, `PBSP_DATA_OFS, 32'h55);
    bus_xfer(1'b1, `PBSP_DIR_OFS, 32'h7F);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    bus_xfer(1'b0, `PBSP_DIR_OFS, 32'h0);
    check(rd, 32'h0);
    bus_xfer(1'b1, `PBSP_DIR_OFS, 32'h7F);
    bus_xfer(1'b0, `PBSP_DATA_OFS, 32'h0);
    check(rd, 32'h55);
    // an unmapped place reads zero and takes no write
    bus_xfer(1'b1, 8'h10, 32'hFFFFFFFF);
    bus_xfer(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    $display("test reset and map done");
    for (int i = 0; i < 40; i++)
    begin
      if (i < 8)
        {dir, pdi, comparator_pin_select, dat, sh} = CORNER[i];
      else
        {dir, pdi, comparator_pin_select, dat, sh} = 28'($urandom);
      bus_xfer(1'b1, `PBSP_DATA_OFS, {25'h0, dat});
      bus_xfer(1'b1, `PBSP_DIR_OFS, {25'h0, dir});
      bus_xfer(1'b1, `PBSP_PDI_OFS, {25'h0, pdi});
      bus_xfer(1'b1, `PBSP_OPT_OFS, {30'h0, comparator_pin_select});
      @(posedge ref_clk);
      shareIn <= sh;
      extEn <= 7'($urandom);
      extVal <= 7'($urandom);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      e = expect_pins();
      m = e[13:7] | dir;
      lm = {e[13] | ~sh.serialPortEnable, e[11], e[10:7]};
      check({25'h0, pinOe}, {25'h0, e[41:35]});
      check({25'h0, pinOut}, {25'h0, e[34:28]});
      check({25'h0, pulldownEn}, {25'h0, e[27:21]});
      check({26'h0, lm & {serialDataIn, analogChannelFour, sharedInput}},
            {26'h0, lm & {e[20] & sh.serialPortEnable, e[18:14]}});
      bus_xfer(1'b0, `PBSP_DATA_OFS, 32'h0);
      check(rd & {25'h0, m}, {25'h0, e[6:0] & m});
      bus_xfer(1'b0, `PBSP_DIR_OFS, 32'h0);
      check(rd, {25'h0, dir});
    end
    $display("test pin sharing done");
    complete_run();
  end
endmodule : testbench
